// file: src/iq_serial_pkg.sv
// Constants and types for the I/Q serial output port
package iq_serial_pkg;
   // Register offsets
   localparam logic [5:0] OFS_CTRL_A = 6'h18;
   localparam logic [5:0] OFS_CTRL_B = 6'h19;
   localparam logic [5:0] OFS_DIV    = 6'h1a;
   // Reset values
   localparam logic [7:0] RST_CTRL_A = 8'h12;
   localparam logic [7:0] RST_CTRL_B = 8'h07;
   localparam logic [3:0] RST_DIV    = 4'h1;
   // Control A bit positions
   localparam int B_ALT_AGC  = 7;
   localparam int B_EMB_AGC  = 6;
   localparam int B_EMB_FS   = 5;
   localparam int B_FS_TRI   = 4;
   localparam int B_FS_INV   = 3;
   localparam int B_LATE_FS  = 2;
   localparam int B_CK_TRI   = 1;
   localparam int B_CK_INV   = 0;
   // Control B bit positions
   localparam int B_FOUR_WIRE = 4;
   localparam int B_WIDTH     = 3;
   localparam int B_DS_HI     = 2;
   // Framing and timing counts
   localparam logic [3:0] SETTLE_SAMPLES = 4'd12;
   localparam logic [3:0] EMB_TAIL_LAST  = 4'd8;
   localparam logic [3:0] EMB_STOP_POS   = 4'd9;
   localparam logic [3:0] RB_BITS        = 4'd8;
   localparam int         SAMPLE_W       = 62;
   // Frame sequencer states, Gray along the embedded-sync path (DATA to IDLE without embedded sync changes both bits)
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_DATA = 2'b11,
      ST_TAIL = 2'b10
   } frame_state_t;
endpackage

// file: src/two_entry_buffer.sv
// Two-entry valid/ready buffer for sample words
`timescale 1ns/100ps
`default_nettype none
module two_entry_buffer #(
   parameter int W = 62
) (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   input  wire logic         ce,
   input  wire logic         flush,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] head_q, head_d, tail_q, tail_d;
   logic [1:0]   cnt_q, cnt_d;
   logic         rdy_q, rdy_d;
   logic         push, pop;

   assign in_ready  = rdy_q;
   assign out_valid = (cnt_q != 2'd0);
   assign out_data  = head_q;

   // Next contents; head always holds the oldest word
   always_comb begin
      push   = in_valid & rdy_q;
      pop    = out_valid & out_ready;
      head_d = head_q;
      tail_d = tail_q;
      cnt_d  = cnt_q;
      if (pop) begin
         head_d = (cnt_q == 2'd2) ? tail_q : in_data;
      end else if (push && cnt_q == 2'd0) begin
         head_d = in_data;
      end
      if (push && (cnt_q == 2'd2 || (cnt_q == 2'd1 && !pop))) begin
         tail_d = in_data;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
      if (flush) begin
         cnt_d = 2'd0;
      end
      rdy_d = (cnt_d != 2'd2);
   end

   // Storage registers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         head_q <= '0;
         tail_q <= '0;
         cnt_q  <= 2'd0;
         rdy_q  <= 1'b0;
      end else if (ce) begin
         head_q <= head_d;
         tail_q <= tail_d;
         cnt_q  <= cnt_d;
         rdy_q  <= rdy_d;
      end
   end
endmodule
`default_nettype wire

// file: src/iq_serial_output_port.sv
// I/Q serial output port: registers, framing, bit clock and frame sync
`timescale 1ns/100ps
`default_nettype none
module iq_serial_output_port (
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic [5:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   input  wire logic        sync_clear_n,
   input  wire logic        agc_override_select,
   input  wire logic        sample_valid,
   output logic             sample_ready,
   input  wire logic [23:0] i_sample,
   input  wire logic [23:0] q_sample,
   input  wire logic [7:0]  agc_atten,
   input  wire logic [5:0]  rssi,
   input  wire logic        mod_reset_evt,
   output logic             bit_clock_out,
   output logic             bit_clock_oe,
   output logic             frame_sync_out,
   output logic             frame_sync_oe,
   output logic             serial_data_out,
   output logic             readback_data_out,
   output logic [2:0]       drive_strength,
   output logic             modulator_clear
);
   import iq_serial_pkg::*;

   // ************************************
   // Functions
   // ************************************
   // Divisor of zero behaves as one
   function automatic logic [3:0] eff_div(input logic [3:0] d);
      eff_div = (d == 4'd0) ? 4'd1 : d;
   endfunction

   // Payload bytes per frame
   function automatic logic [3:0] frame_bytes(input logic w24, input logic embed_agc_bytes, input logic alternate_agc_bytes);
      logic [3:0] n;
      n = w24 ? 4'd6 : 4'd4;
      if (embed_agc_bytes) begin
         n = n + (alternate_agc_bytes ? 4'd1 : 4'd2);
      end
      frame_bytes = n;
   endfunction

   // ************************************
   // Registers
   // ************************************
   logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d, rdata_q, rdata_d, rb_q, rb_d;
   logic [3:0] div_q, div_d, rbn_q, rbn_d;
   logic       rbo_q, rbo_d;

   // Register writes, reads and serial readback
   always_comb begin
      ctrl_a_d = ctrl_a_q;
      ctrl_b_d = ctrl_b_q;
      div_d    = div_q;
      rdata_d  = rdata_q;
      rb_d     = {rb_q[6:0], 1'b0};
      rbn_d    = (rbn_q != 4'd0) ? rbn_q - 4'd1 : 4'd0;
      rbo_d    = (rbn_q != 4'd0) ? rb_q[7] : 1'b0;
      if (reg_wr && reg_addr == OFS_CTRL_A) begin
         ctrl_a_d = reg_wdata;
      end else if (reg_wr && reg_addr == OFS_CTRL_B) begin
         ctrl_b_d = {3'b000, reg_wdata[4:0]};
      end else if (reg_wr && reg_addr == OFS_DIV) begin
         div_d = reg_wdata[3:0];
      end
      if (reg_rd) begin
         if (reg_addr == OFS_CTRL_A) begin
            rdata_d = ctrl_a_q;
         end else if (reg_addr == OFS_CTRL_B) begin
            rdata_d = ctrl_b_q;
         end else if (reg_addr == OFS_DIV) begin
            rdata_d = {4'h0, div_q};
         end else begin
            rdata_d = 8'h00;
         end
         if (ctrl_b_q[B_FOUR_WIRE]) begin
            rb_d  = rdata_d;
            rbn_d = RB_BITS;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_a_q <= RST_CTRL_A;
         ctrl_b_q <= RST_CTRL_B;
         div_q    <= RST_DIV;
         rdata_q  <= 8'h00;
         rb_q     <= 8'h00;
         rbn_q    <= 4'd0;
         rbo_q    <= 1'b0;
      end else if (ce) begin
         ctrl_a_q <= ctrl_a_d;
         ctrl_b_q <= ctrl_b_d;
         div_q    <= div_d;
         rdata_q  <= rdata_d;
         rb_q     <= rb_d;
         rbn_q    <= rbn_d;
         rbo_q    <= rbo_d;
      end
   end

   // ************************************
   // Sample buffer
   // ************************************
   logic [SAMPLE_W-1:0] buf_data;
   logic                buf_valid, buf_pop;

   two_entry_buffer #(.W(SAMPLE_W)) u_buf (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .ce        (ce),
      .flush     (!sync_clear_n),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   ({i_sample, q_sample, agc_atten, rssi}),
      .out_valid (buf_valid),
      .out_ready (buf_pop),
      .out_data  (buf_data)
   );

   // ************************************
   // Framing
   // ************************************
   frame_state_t state_q, state_d;
   logic [3:0]  cnt_q, cnt_d, bit_q, bit_d, byte_q, byte_d, nby_q, nby_d, settle_q, settle_d;
   logic [63:0] pay_q, pay_d;
   logic [7:0]  b0, b1, stat;
   logic [1:0]  rcnt_q, rcnt_d;
   logic        efs_q, efs_d, alt_q, alt_d, sck_d, fs_q, fs_d, dout_q, dout_d;
   logic        syncp_q, mclr_q, tick, w24, alternate_agc_bytes, embed_agc_bytes, send_stat, ck_lvl, fs_lvl, fs_raw;
   logic        bit_ckq, bit_ckoe_q, fsq_out, fsoe_q;
   logic [3:0]  dv;

   // Frame sequencing, bit clock and data bit selection
   always_comb begin
      dv       = eff_div(div_q);
      tick     = (cnt_q >= dv - 4'd1);
      cnt_d    = tick ? 4'd0 : cnt_q + 4'd1;
      // width forced to 16 by override
      w24      = ctrl_b_q[B_WIDTH] & ~agc_override_select;
      alternate_agc_bytes     = ctrl_a_q[B_ALT_AGC];
      embed_agc_bytes     = ctrl_a_q[B_EMB_AGC];
      state_d  = state_q;
      bit_d    = bit_q;
      byte_d   = byte_q;
      nby_d    = nby_q;
      pay_d    = pay_q;
      efs_d    = efs_q;
      alt_d    = alt_q;
      settle_d = settle_q;
      fs_d     = fs_q;
      dout_d   = dout_q;
      buf_pop  = 1'b0;
      // status byte and saturating reset count
      stat      = {rcnt_q, buf_data[5:0]};
      send_stat = embed_agc_bytes & (~alternate_agc_bytes | alt_q);
      rcnt_d    = rcnt_q;
      b0 = alternate_agc_bytes ? (alt_q ? {stat[7:1], 1'b1} : {buf_data[13:7], 1'b0}) : buf_data[13:6];
      b1 = alternate_agc_bytes ? 8'hff : stat;
      if (tick) begin
         fs_d = 1'b0;
         case (state_q)
            ST_IDLE: begin
               dout_d = 1'b1;
               if (buf_valid) begin
                  buf_pop = 1'b1;
                  // drop samples disturbed by the modulator reset
                  if (settle_q < SETTLE_SAMPLES) begin
                     settle_d = settle_q + 4'd1;
                  end else begin
                     // I, Q then optional bytes, MSB first
                     pay_d = w24 ? {buf_data[61:14], (embed_agc_bytes ? {b0, b1} : 16'hffff)}
                                 : {buf_data[61:46], buf_data[37:22], (embed_agc_bytes ? {b0, b1} : 16'hffff), 16'hffff};
                     // frame length from width and AGC bytes
                     nby_d   = frame_bytes(w24, embed_agc_bytes, alternate_agc_bytes);
                     efs_d   = ctrl_a_q[B_EMB_FS];
                     alt_d   = alternate_agc_bytes ? ~alt_q : 1'b0;
                     bit_d   = 4'd0;
                     byte_d  = 4'd0;
                     state_d = ST_LEAD;
                     // early sync pulse before first bit
                     fs_d    = ~ctrl_a_q[B_EMB_FS] & ~ctrl_a_q[B_LATE_FS];
                     if (send_stat) begin
                        rcnt_d = 2'd0;
                     end
                  end
               end
            end
            ST_LEAD: begin
               // late pulse aligned with first bit
               fs_d    = ~efs_q & ctrl_a_q[B_LATE_FS];
               dout_d  = efs_q ? 1'b0 : pay_q[63];
               state_d = ST_DATA;
            end
            ST_DATA: begin
               if (!efs_q) begin
                  pay_d = {pay_q[62:0], 1'b1};
                  bit_d = (bit_q == 4'd7) ? 4'd0 : bit_q + 4'd1;
                  if (bit_q == 4'd7) begin
                     byte_d = byte_q + 4'd1;
                  end
                  dout_d = pay_d[63];
                  if (bit_q == 4'd7 && byte_q == nby_q - 4'd1) begin
                     state_d = ST_IDLE;
                     dout_d  = 1'b1;
                  end
               end else begin
                  // start, eight data, stop per byte
                  if (bit_q != 4'd0 && bit_q != EMB_STOP_POS) begin
                     pay_d = {pay_q[62:0], 1'b1};
                  end
                  bit_d  = (bit_q == EMB_STOP_POS) ? 4'd0 : bit_q + 4'd1;
                  byte_d = (bit_q == EMB_STOP_POS) ? byte_q + 4'd1 : byte_q;
                  dout_d = (bit_d == 4'd0) ? 1'b0 : (bit_d == EMB_STOP_POS) ? 1'b1 : pay_d[63];
                  // idle tail after the last stop bit
                  if (bit_q == EMB_STOP_POS && byte_q == nby_q - 4'd1) begin
                     state_d = ST_TAIL;
                     bit_d   = 4'd0;
                     dout_d  = 1'b1;
                  end
               end
            end
            ST_TAIL: begin
               dout_d = 1'b1;
               bit_d  = bit_q + 4'd1;
               if (bit_q == EMB_TAIL_LAST) begin
                  state_d = ST_IDLE;
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end
      // Reset events counted, set wins over clear
      if (mod_reset_evt || (syncp_q && !sync_clear_n)) begin
         rcnt_d = (rcnt_d == 2'd0) ? 2'd1 : ((rcnt_d == 2'd3) ? 2'd3 : rcnt_d + 2'd1);
      end
      // sync clears port counters and sequencer
      if (!sync_clear_n) begin
         cnt_d    = 4'd0;
         state_d  = ST_IDLE;
         bit_d    = 4'd0;
         byte_d   = 4'd0;
         settle_d = 4'd0;
         fs_d     = 1'b0;
         dout_d   = 1'b1;
      end
      // bit clock rises when a new bit starts, at divisors above one
      sck_d  = ({1'b0, cnt_d} < (({1'b0, dv} + 5'd1) >> 1));
      ck_lvl = sync_clear_n ? (sck_d ^ ctrl_a_q[B_CK_INV]) : 1'b1;
      fs_raw = fs_d ^ ctrl_a_q[B_FS_INV];
      fs_lvl = (sync_clear_n && !ctrl_a_q[B_EMB_FS]) ? fs_raw : 1'b0;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q    <= ST_IDLE;
         cnt_q      <= 4'd0;
         bit_q      <= 4'd0;
         byte_q     <= 4'd0;
         nby_q      <= 4'd0;
         settle_q   <= 4'd0;
         pay_q      <= '1;
         rcnt_q     <= 2'd0;
         efs_q      <= 1'b0;
         alt_q      <= 1'b0;
         fs_q       <= 1'b0;
         dout_q     <= 1'b1;
         syncp_q    <= 1'b1;
         mclr_q     <= 1'b0;
         bit_ckq    <= 1'b1;
         bit_ckoe_q <= 1'b0;
         fsq_out    <= 1'b0;
         fsoe_q     <= 1'b0;
      end else if (ce) begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         bit_q      <= bit_d;
         byte_q     <= byte_d;
         nby_q      <= nby_d;
         settle_q   <= settle_d;
         pay_q      <= pay_d;
         rcnt_q     <= rcnt_d;
         efs_q      <= efs_d;
         alt_q      <= alt_d;
         fs_q       <= fs_d;
         dout_q     <= dout_d;
         syncp_q    <= sync_clear_n;
         // modulator held in reset with sync
         mclr_q     <= ~sync_clear_n;
         // clock high, sync low during sync
         bit_ckq    <= ck_lvl;
         bit_ckoe_q <= ~ctrl_a_q[B_CK_TRI];
         fsq_out    <= fs_lvl;
         fsoe_q     <= ~ctrl_a_q[B_FS_TRI];
      end
   end

   // ************************************
   // Outputs
   // ************************************
   assign reg_rdata         = rdata_q;
   assign readback_data_out = rbo_q;
   assign drive_strength    = ctrl_b_q[B_DS_HI:0];
   assign bit_clock_out     = bit_ckq;
   assign bit_clock_oe      = bit_ckoe_q;
   assign frame_sync_out    = fsq_out;
   assign frame_sync_oe     = fsoe_q;
   assign serial_data_out   = dout_q;
   assign modulator_clear   = mclr_q;
endmodule
`default_nettype wire

// file: tb/iq_serial_output_port_asserts.sv
// Port checker for the I/Q serial output port
`timescale 1ns/100ps
`default_nettype none
module iq_serial_output_port_asserts
   import iq_serial_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic       ce,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       sync_clear_n,
   input wire logic       bit_clock_out,
   input wire logic       bit_clock_oe,
   input wire logic       frame_sync_out,
   input wire logic       frame_sync_oe,
   input wire logic       serial_data_out,
   input wire logic       readback_data_out,
   input wire logic [2:0] drive_strength,
   input wire logic       modulator_clear
);
   // ******************************
   // Register shadows and counters
   // ******************************
   logic [7:0] sa_q, sb_q, rb_q, rd_exp;
   logic [3:0] sd_q, per_q, fsw_q;
   logic       arm_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Expected read data for the addressed place
   assign rd_exp = (reg_addr == OFS_CTRL_A) ? sa_q : (reg_addr == OFS_CTRL_B) ? sb_q :
                   (reg_addr == OFS_DIV) ? {4'h0, sd_q} : 8'h00;
   // Shadows, bit period and sync width counters
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sa_q <= RST_CTRL_A;
         sb_q <= RST_CTRL_B;
         sd_q <= RST_DIV;
         rb_q <= 8'h00;
         per_q <= 4'h0;
         fsw_q <= 4'h0;
         arm_q <= 1'b0;
      end else begin
         if (ce && reg_wr && reg_addr == OFS_CTRL_A) sa_q <= reg_wdata;
         if (ce && reg_wr && reg_addr == OFS_CTRL_B) sb_q <= reg_wdata & 8'h1f;
         if (ce && reg_wr && reg_addr == OFS_DIV) sd_q <= reg_wdata[3:0];
         rb_q <= (ce && reg_rd) ? sb_q : {rb_q[6:0], 1'b0};
         per_q <= $rose(bit_clock_out) ? 4'h1 : per_q + 4'h1;
         fsw_q <= frame_sync_out ? fsw_q + 4'h1 : 4'h0;
         arm_q <= (!sync_clear_n || reg_wr || $past(reg_wr)) ? 1'b0 : ($rose(bit_clock_out) || arm_q);
      end
   end
   sequence s_rb_req;
      ce && reg_rd && reg_addr == OFS_CTRL_B && sb_q[B_FOUR_WIRE];
   endsequence
   sequence s_rb_bits;
      (readback_data_out == $past(rb_q[7])) [*8];
   endsequence
   a_read_value: assert property (ce && reg_rd |=> reg_rdata == $past(rd_exp))
      else $error("read data differs from register contents");
   a_readback_serial: assert property (s_rb_req |=> ##1 s_rb_bits)
      else $error("readback bits out of order");
   a_drive_field: assert property ($stable(sb_q) |-> drive_strength == sb_q[2:0])
      else $error("drive strength differs from field");
   a_pin_enable: assert property (sa_q == $past(sa_q) |->
      bit_clock_oe == !sa_q[B_CK_TRI] && frame_sync_oe == !sa_q[B_FS_TRI])
      else $error("pin enable differs from tristate bits");
   a_sync_hold: assert property (!sync_clear_n && $past(!sync_clear_n) && !sa_q[B_CK_INV] &&
      !sa_q[B_FS_INV] |-> bit_clock_out && !frame_sync_out && serial_data_out)
      else $error("outputs not parked during sync");
   a_clear_pulse: assert property ($rose(sync_clear_n) |-> modulator_clear ##1 !modulator_clear)
      else $error("modulator clear does not follow sync");
   a_bit_period: assert property ($rose(bit_clock_out) && arm_q && sd_q > 4'h1 |-> per_q == sd_q)
      else $error("bit clock period differs from divisor");
   a_sync_width: assert property ($fell(frame_sync_out) && arm_q && !sa_q[B_FS_INV] &&
      sd_q > 4'h1 |-> fsw_q == sd_q)
      else $error("frame sync pulse not one bit long");
   a_edge_align: assert property (arm_q && sd_q > 4'h1 && !sa_q[B_CK_INV] &&
      (!$stable(serial_data_out) || !$stable(frame_sync_out)) |-> $rose(bit_clock_out))
      else $error("data or sync moved off the bit clock rise");
   a_embedded_quiet: assert property (sa_q[B_EMB_FS] && $past(sa_q, 8) == sa_q &&
      !sa_q[B_FS_INV] |-> !frame_sync_out)
      else $error("frame sync active in embedded mode");
endmodule
bind iq_serial_output_port iq_serial_output_port_asserts i_chk (
   .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_clear_n(sync_clear_n),
   .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe), .frame_sync_out(frame_sync_out),
   .frame_sync_oe(frame_sync_oe), .serial_data_out(serial_data_out),
   .readback_data_out(readback_data_out), .drive_strength(drive_strength),
   .modulator_clear(modulator_clear)
);
`default_nettype wire

// file: tb/host_serial_receiver.sv
// Host serial receive model collecting frames
`timescale 1ns/100ps
`default_nettype none
module host_serial_receiver (
   input  wire logic       bit_clock_in,
   input  wire logic       frame_sync_in,
   input  wire logic       data_in,
   input  wire logic       active,
   input  wire logic       clock_inv,
   input  wire logic       sync_inv,
   input  wire logic       late_sync,
   input  wire logic [6:0] frame_bits,
   output logic [63:0]     frame_word,
   output logic [15:0]     frame_count
);
   // ******************************
   // Bit capture
   // ******************************
   logic sclk;
   int   left;
   assign sclk = bit_clock_in ^ clock_inv;
   initial begin
      frame_word = 64'h0;
      frame_count = 16'h0;
      left = 0;
   end
   // sample mid-bit, late sync on first bit
   always @(negedge sclk or negedge active) begin
      if (!active) begin
         left = 0;
      end else if (left > 0) begin
         frame_word = {frame_word[62:0], data_in};
         left--;
         if (left == 0) frame_count++;
      end else if (frame_sync_in ^ sync_inv) begin
         frame_word = late_sync ? {63'h0, data_in} : 64'h0;
         left = int'(frame_bits) - int'(late_sync);
      end
   end
endmodule
`default_nettype wire

// file: tb/iq_serial_output_port_bench.sv
// Self-checking bench for the I/Q serial output port
`timescale 1ns/100ps
`default_nettype none
module iq_serial_output_port_bench;
   import iq_serial_pkg::*;
   logic        clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [5:0]  reg_addr = 6'h00;
   logic [7:0]  reg_wdata = 8'h00, agc_atten = 8'h00, reg_rdata;
   logic        sync_clear_n = 1'b1, agc_override_select = 1'b0, sample_valid = 1'b0;
   logic [23:0] i_sample = 24'h0, q_sample = 24'h0;
   logic [5:0]  rssi = 6'h00;
   logic        mod_reset_evt = 1'b0, full_seen = 1'b0, w24 = 1'b0, agc = 1'b0;
   logic        sample_ready, bit_clock_out, bit_clock_oe, frame_sync_out, frame_sync_oe;
   logic        serial_data_out, readback_data_out, modulator_clear;
   logic [2:0]  drive_strength;
   logic        late = 1'b0, cki = 1'b0, fsi = 1'b0, alt = 1'b0, ph = 1'b0;
   logic [6:0]  nbits = 7'd32;
   logic [63:0] frame_word, exp_q[$], msk_q[$];
   logic [15:0] frame_count;
   logic [7:0]  cfg_a[7] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h40, 8'h09, 8'hc0};
   logic [7:0]  cfg_b[7] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00};
   logic [7:0]  cfg_d[7] = '{8'h02, 8'h03, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
   int          mismatches = 0, checked = 0;
   iq_serial_output_port i_dut (
      .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_clear_n(sync_clear_n),
      .agc_override_select(agc_override_select), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .i_sample(i_sample), .q_sample(q_sample),
      .agc_atten(agc_atten), .rssi(rssi), .mod_reset_evt(mod_reset_evt),
      .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe), .frame_sync_out(frame_sync_out),
      .frame_sync_oe(frame_sync_oe), .serial_data_out(serial_data_out),
      .readback_data_out(readback_data_out), .drive_strength(drive_strength),
      .modulator_clear(modulator_clear));
   host_serial_receiver i_host (
      .bit_clock_in(bit_clock_out), .frame_sync_in(frame_sync_out), .data_in(serial_data_out),
      .active(sync_clear_n), .clock_inv(cki), .sync_inv(fsi), .late_sync(late), .frame_bits(nbits),
      .frame_word(frame_word), .frame_count(frame_count));
   // ******************************
   // Shared tasks
   // ******************************
   task automatic check(input string what, input logic [63:0] expv, input logic [63:0] seen);
      checked++;
      if (seen !== expv) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, expv, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #10;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      step(1);
      reg_wr = 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic rb);
      reg_addr = a;
      reg_rd = 1'b1;
      step(1);
      reg_rd = 1'b0;
      check("reg_rdata", e, reg_rdata);
      for (int k = 7; k >= 0 && rb; k--) begin
         step(1);
         check("readback bit", e[k], readback_data_out); // serial readback
      end
      if (!rb) step(1);
   endtask
   // Offer one random sample, noting its frame when kept
   task automatic send(input logic keep);
      logic [63:0] f;
      int n;
      i_sample = 24'($urandom);
      q_sample = 24'($urandom);
      f = w24 ? {16'h0, i_sample, q_sample} : {32'h0, i_sample[23:8], q_sample[23:8]};
      if (alt) f = {f[55:0], ph ? {2'b00, rssi[5:1], 1'b1} : {agc_atten[7:1], 1'b0}};
      else if (agc) f = {f[47:0], agc_atten, 2'b00, rssi};
      if (keep) exp_q.push_back(f);
      if (keep) msk_q.push_back((agc && (!alt || ph)) ? ~64'hc0 : ~64'h0);
      if (keep) ph = ph ^ alt;
      sample_valid = 1'b1;
      n = 0;
      while (sample_ready !== 1'b1 && n < 5000) begin
         step(1);
         n++;
      end
      if (n == 5000) check("sample_ready wait", 64'h1, 64'h0);
      if (n == 5000) print_verdict();
      step(1);
   endtask
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      check("run length", 64'h0, 64'h1);
      print_verdict();
   end
   // Random modulator reset pulses
   initial begin
      forever begin
         step(1);
         mod_reset_evt = ($urandom % 13) == 0;
      end
   end
   always @(posedge clk_sys) begin
      if (sample_valid && !sample_ready) full_seen <= 1'b1;
   end
   // Compare each received frame with the oldest note
   initial begin
      forever begin
         @(frame_count);
         if (exp_q.size() == 0) begin
            check("unexpected frame", 64'h0, 64'h1); // settling samples dropped
         end else begin
            check("frame", exp_q.pop_front(), frame_word & msk_q.pop_front()); // layout
         end
      end
   end
   // ******************************
   // Main sequence
   // ******************************
   initial begin
      int n;
      void'($urandom(1));
      step(3);
      nrst = 1'b1;
      step(1);
      rd(OFS_CTRL_A, RST_CTRL_A, 1'b0); // reset value
      rd(OFS_CTRL_B, RST_CTRL_B, 1'b0); // reset value
      rd(OFS_DIV, 8'h01, 1'b0); // reset value
      rd(6'h3f, 8'h00, 1'b0); // unmapped read
      check("drive_strength", 64'h7, drive_strength); // reset strength
      wr(OFS_CTRL_B, 8'hff);
      rd(OFS_CTRL_B, 8'h1f, 1'b1); // four-wire readback
      wr(OFS_DIV, 8'hf3);
      rd(OFS_DIV, 8'h03, 1'b0); // divisor field
      for (int c = 0; c < 7; c++) begin
         wr(OFS_CTRL_A, cfg_a[c]);
         wr(OFS_CTRL_B, cfg_b[c]);
         wr(OFS_DIV, cfg_d[c]);
         check("drive_strength", {61'h0, cfg_b[c][2:0]}, {61'h0, drive_strength}); // field follows write
         // sync held low four cycles, host retuned meanwhile
         sync_clear_n = 1'b0;
         agc_override_select = (c == 3);
         w24 = cfg_b[c][B_WIDTH] & (c != 3);
         alt = cfg_a[c][B_ALT_AGC];
         agc = cfg_a[c][B_EMB_AGC];
         late = cfg_a[c][B_LATE_FS];
         cki = cfg_a[c][B_CK_INV];
         fsi = cfg_a[c][B_FS_INV];
         nbits = (w24 ? 7'd48 : 7'd32) + (agc ? (alt ? 7'd8 : 7'd16) : 7'd0);
         agc_atten = 8'($urandom);
         rssi = 6'($urandom);
         step(4);
         sync_clear_n = 1'b1;
         repeat (12) send(1'b0);
         repeat (6) send(1'b1);
         sample_valid = 1'b0;
         n = 0;
         while (exp_q.size() != 0 && n < 20000) begin
            step(1);
            n++;
         end
         if (n == 20000) check("frames drained", 64'h0, 64'h1);
         step(10 * cfg_d[c]);
      end
      wr(OFS_CTRL_A, 8'h20);
      step(40);
      check("buffer refused", 64'h1, full_seen); // stall fills the buffer
      print_verdict();
   end
endmodule
`default_nettype wire
